// >>> common/panel_pkg.sv
// panel_pkg: shared constants and types for the front panel controller
// assumes a 200 MHz clock and raw key levels synchronous to it
`default_nettype none
package panel_pkg;
   // clock period and key debounce time
   localparam int CLK_PERIOD_NS  = 5;
   localparam int DEBOUNCE_US    = 10000;
   localparam int DEBOUNCE_CYC   = (DEBOUNCE_US * 1000) / CLK_PERIOD_NS;
   // key indices
   localparam int KEY_COUNT      = 16;
   localparam int K_MODE         = 0;
   localparam int K_PRESET       = 1;
   localparam int K_LOAD         = 2;
   localparam int K_LEVEL        = 3;
   localparam int K_DYNSTA       = 4;
   localparam int K_SHORT        = 5;
   localparam int K_LIMIT        = 6;
   localparam int K_HIGH_PER     = 7;
   localparam int K_LOW_PER      = 8;
   localparam int K_RISE         = 9;
   localparam int K_FALL         = 10;
   localparam int K_HIGH_LVL     = 11;
   localparam int K_LOW_LVL      = 12;
   localparam int K_COARSE_UP    = 13;
   localparam int K_COARSE_DN    = 14;
   localparam int K_FINE         = 15;
   // limit menu positions
   localparam int MENU_LAST      = 15;
   localparam int VAL_W          = 16;
   // protection codes on the lower meter
   localparam logic [2:0] PROT_NONE = 3'h0;
   localparam logic [2:0] PROT_OV   = 3'h1;
   localparam logic [2:0] PROT_OC   = 3'h2;
   localparam logic [2:0] PROT_OP   = 3'h3;
   localparam logic [2:0] PROT_OT   = 3'h4;
   // regulation mode, gray along the cycle
   typedef enum logic [1:0] {
      const_current_mode    = 2'h0,
      const_resistance_mode = 2'h1,
      const_voltage_mode    = 2'h3,
      const_power_mode      = 2'h2
   } reg_mode_t;
   // display mode
   typedef enum logic [1:0] {
      PRESET_ON  = 2'h0,
      WATT_ON    = 2'h1,
      PRESET_OFF = 2'h3
   } disp_mode_t;
   // upper / lower meter source selects
   typedef enum logic [2:0] {
      SRC_VOLT   = 3'h0,
      SRC_PROG   = 3'h1,
      SRC_POWER  = 3'h2,
      SRC_LIMIT  = 3'h3,
      SRC_CURR   = 3'h4,
      SRC_SHORT  = 3'h5,
      SRC_PROT   = 3'h6,
      SRC_LOWLIM = 3'h7
   } meter_src_t;
   // parameter under programming
   typedef enum logic [2:0] {
      SEL_HIGH_LVL = 3'h0,
      SEL_LOW_LVL  = 3'h1,
      SEL_HIGH_PER = 3'h2,
      SEL_LOW_PER  = 3'h3,
      SEL_RISE     = 3'h4,
      SEL_FALL     = 3'h5
   } prog_sel_t;
endpackage : panel_pkg
`default_nettype wire

// >>> design/key_debounce.sv
// key_debounce: one press pulse per stable closure of each key
// assumes key levels active high and synchronous to CLK
`default_nettype none
module key_debounce #(
   parameter int KEYS    = panel_pkg::KEY_COUNT,
   parameter int STABLE  = panel_pkg::DEBOUNCE_CYC
) (
   // clock and reset
   input  wire logic            clk,
   input  wire logic            reset,
   // raw keys and pulses
   input  wire logic [KEYS-1:0] raw,
   output logic      [KEYS-1:0] press
);
   localparam int CW = $clog2(STABLE + 1);
   // refuse settings the counter cannot serve
   if (KEYS < 1 || STABLE < 1) begin : g_bad_param
      $error("key_debounce: bad parameters");
   end
   genvar i;
   generate
      for (i = 0; i < KEYS; i++) begin : g_key
         logic [CW-1:0] cnt;
         logic [CW-1:0] next_cnt;
         logic          stable;
         logic          next_stable;
         logic          next_press;
         always_comb begin
            next_cnt    = cnt;
            next_stable = stable;
            next_press  = 1'b0;
            if (raw[i] == stable) begin
               next_cnt = '0;
            end else if (cnt == CW'(STABLE - 1)) begin
               next_cnt    = '0;
               next_stable = raw[i];
               next_press  = raw[i];
            end else begin
               next_cnt = cnt + 1'b1;
            end
         end
         always_ff @(posedge clk) begin
            if (reset) begin
               cnt      <= '0;
               stable   <= 1'b0;
               press[i] <= 1'b0;
            end else begin
               cnt      <= next_cnt;
               stable   <= next_stable;
               press[i] <= next_press;
            end
         end
      end
   endgenerate
endmodule : key_debounce
`default_nettype wire

// >>> design/load_front_panel_controller.sv
// load_front_panel_controller: keys, indicators and meter selects
// assumes the analog side gives pass/fail compares and protection flags
//
// Contract
// - mode key steps current, resistance, voltage, power, then wraps
// - exactly one mode lamp lit, the active mode
// - fail lamp lit when any reading is outside its limits
// - remote lamp lit and keys ignored while remote is active
// - preset key cycles preset-on, watt-on, preset-off
// - preset lamp amber, green or dark by display mode
// - load key toggles sinking, settings untouched
// - load lamp lit while load function on
// - level key toggles high/low in static only, lamp lit for high
// - dynamic key toggles only in current or power mode
// - resistance or voltage mode forces static
// - short key toggles input short, lamp lit while shorted
// - limit key steps fixed setup menu and wraps to off
// - limit lamp lit at any menu position but off
// - one value shown: large arrows coarse, small arrows fine
// - two values shown: large arrows upper, small arrows lower
// - upper meter source follows display mode and limit menu
// - preset-off lower meter shows load or short current
// - active protection puts its code on the lower meter
// - period keys select high or low duration, lamp follows
// - rise and fall keys select slew programming, lamp follows
// - level keys select high or low value programming, lamp follows
`default_nettype none
module load_front_panel_controller
   import panel_pkg::*;
#(
   parameter int DEBOUNCE = DEBOUNCE_CYC
) (
   // clock and reset
   input  wire logic                   CLK,
   input  wire logic                   RESET,
   // raw keys, active high
   input  wire logic [KEY_COUNT-1:0]   KEYS,
   // fine arrow direction, high for up
   input  wire logic                   FINE_UP,
   // remote control active
   input  wire logic                   REMOTE_ACTIVE,
   // limit compares from the meters
   input  wire logic [2:0]             ABOVE_UPPER,
   input  wire logic [2:0]             BELOW_LOWER,
   // protection flags: ov, oc, op, ot
   input  wire logic [3:0]             PROT_FLAGS,
   // regulation state
   output logic [3:0]                  MODE_LEDS,
   output reg_mode_t                   REG_MODE,
   output logic                        DYNAMIC,
   output logic                        HIGH_LEVEL,
   output logic                        LOAD_ON,
   output logic                        SHORT_ON,
   // indicators
   output logic                        FAIL_INDICATOR,
   output logic                        REMOTE_INDICATOR,
   output logic                        PRESET_AMBER,
   output logic                        PRESET_GREEN,
   output logic                        LOAD_LED,
   output logic                        LEVEL_LED,
   output logic                        DYN_LED,
   output logic                        SHORT_LED,
   output logic                        LIMIT_LED,
   output logic [5:0]                  PROG_LEDS,
   // display and menu
   output disp_mode_t                  DISP_MODE,
   output logic [3:0]                  MENU_POS,
   output prog_sel_t                   PROG_SEL,
   output meter_src_t                  UPPER_SRC,
   output meter_src_t                  LOWER_SRC,
   output logic [2:0]                  PROT_CODE,
   // adjust pulses: +1 / -1 on upper or lower value
   output logic                        ADJ_UPPER_INC,
   output logic                        ADJ_UPPER_DEC,
   output logic                        ADJ_LOWER_INC,
   output logic                        ADJ_LOWER_DEC,
   output logic                        ADJ_COARSE
);
   // refuse a debounce the counter cannot serve
   if (DEBOUNCE < 1) begin : g_bad_debounce
      $error("load_front_panel_controller: DEBOUNCE below one");
   end
   // menu position is four bits wide
   if (MENU_LAST < 1 || MENU_LAST > 15) begin : g_bad_menu
      $error("load_front_panel_controller: menu length unsupported");
   end
   // key indices reach fifteen
   if (KEY_COUNT != 16) begin : g_bad_keys
      $error("load_front_panel_controller: sixteen keys expected");
   end

   logic [KEY_COUNT-1:0] press;
   logic [KEY_COUNT-1:0] key;

   key_debounce #(
      .KEYS   (KEY_COUNT),
      .STABLE (DEBOUNCE)
   ) u_deb (
      .clk    (CLK),
      .reset  (RESET),
      .raw    (KEYS),
      .press  (press)
   );

   assign key = REMOTE_ACTIVE ? '0 : press;

   reg_mode_t  mode;
   reg_mode_t  next_mode;
   disp_mode_t disp;
   disp_mode_t next_disp;
   prog_sel_t  sel;
   prog_sel_t  next_sel;
   logic [3:0] menu;
   logic [3:0] next_menu;
   logic       dyn;
   logic       next_dyn;
   logic       hi;
   logic       next_hi;
   logic       load;
   logic       next_load;
   logic       shrt;
   logic       next_shrt;
   logic       two_vals;
   logic       any_up;
   logic       any_dn;

   always_comb begin
      next_mode = mode;
      next_disp = disp;
      next_sel  = sel;
      next_menu = menu;
      next_dyn  = dyn;
      next_hi   = hi;
      next_load = load;
      next_shrt = shrt;
      if (key[K_MODE]) begin
         case (mode)
            const_current_mode:    next_mode = const_resistance_mode;
            const_resistance_mode: next_mode = const_voltage_mode;
            const_voltage_mode:    next_mode = const_power_mode;
            const_power_mode:      next_mode = const_current_mode;
            default:               next_mode = const_current_mode;
         endcase
      end
      if (key[K_PRESET]) begin
         case (disp)
            PRESET_ON:  next_disp = WATT_ON;
            WATT_ON:    next_disp = PRESET_OFF;
            PRESET_OFF: next_disp = PRESET_ON;
            default:    next_disp = PRESET_ON;
         endcase
      end
      if (key[K_LOAD])
         next_load = ~load;
      if (key[K_SHORT])
         next_shrt = ~shrt;
      if (key[K_LIMIT])
         next_menu = (menu == 4'(MENU_LAST)) ? 4'h0 : menu + 4'h1;
      // dynamic toggle in current or power only
      if (key[K_DYNSTA] && (mode == const_current_mode ||
                            mode == const_power_mode))
         next_dyn = ~dyn;
      // force static in resistance or voltage
      if (next_mode == const_resistance_mode ||
          next_mode == const_voltage_mode)
         next_dyn = 1'b0;
      if (key[K_LEVEL] && !dyn)
         next_hi = ~hi;
      if (key[K_HIGH_LVL])
         next_sel = SEL_HIGH_LVL;
      if (key[K_LOW_LVL])
         next_sel = SEL_LOW_LVL;
      if (key[K_HIGH_PER])
         next_sel = SEL_HIGH_PER;
      if (key[K_LOW_PER])
         next_sel = SEL_LOW_PER;
      if (key[K_RISE])
         next_sel = SEL_RISE;
      if (key[K_FALL])
         next_sel = SEL_FALL;
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         mode <= const_current_mode;
         disp <= PRESET_OFF;
         sel  <= SEL_HIGH_LVL;
         menu <= 4'h0;
         dyn  <= 1'b0;
         hi   <= 1'b0;
         load <= 1'b0;
         shrt <= 1'b0;
      end else begin
         mode <= next_mode;
         disp <= next_disp;
         sel  <= next_sel;
         menu <= next_menu;
         dyn  <= next_dyn;
         hi   <= next_hi;
         load <= next_load;
         shrt <= next_shrt;
      end
   end

   // menu positions 1..3 show an upper and a lower limit
   assign two_vals = (menu >= 4'h1) && (menu <= 4'h3);
   assign any_up   = key[K_COARSE_UP] | (key[K_FINE] & FINE_UP);
   assign any_dn   = key[K_COARSE_DN] | (key[K_FINE] & ~FINE_UP);

   logic       next_uinc;
   logic       next_udec;
   logic       next_linc;
   logic       next_ldec;
   logic       next_coarse;
   meter_src_t next_usrc;
   meter_src_t next_lsrc;
   logic [2:0] next_pcode;
   logic       next_fail;

   always_comb begin
      next_uinc   = 1'b0;
      next_udec   = 1'b0;
      next_linc   = 1'b0;
      next_ldec   = 1'b0;
      next_coarse = 1'b0;
      if (two_vals) begin
         // large arrows upper, small arrows lower
         next_uinc = key[K_COARSE_UP];
         next_udec = key[K_COARSE_DN];
         next_linc = key[K_FINE] & FINE_UP;
         next_ldec = key[K_FINE] & ~FINE_UP;
      end else begin
         // coarse or fine step on single value
         next_uinc   = any_up;
         next_udec   = any_dn;
         next_coarse = key[K_COARSE_UP] | key[K_COARSE_DN];
      end
      if (menu != 4'h0)
         next_usrc = SRC_LIMIT;
      else begin
         case (disp)
            PRESET_ON: next_usrc = SRC_PROG;
            WATT_ON:   next_usrc = SRC_POWER;
            default:   next_usrc = SRC_VOLT;
         endcase
      end
      if (PROT_FLAGS[0])
         next_pcode = PROT_OV;
      else if (PROT_FLAGS[1])
         next_pcode = PROT_OC;
      else if (PROT_FLAGS[2])
         next_pcode = PROT_OP;
      else if (PROT_FLAGS[3])
         next_pcode = PROT_OT;
      else
         next_pcode = PROT_NONE;
      if (next_pcode != PROT_NONE)
         next_lsrc = SRC_PROT;
      else if (menu != 4'h0)
         next_lsrc = SRC_LOWLIM;
      else if (disp == PRESET_ON)
         next_lsrc = SRC_PROG;
      else
         next_lsrc = shrt ? SRC_SHORT : SRC_CURR;
      next_fail = |(ABOVE_UPPER | BELOW_LOWER);
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         ADJ_UPPER_INC  <= 1'b0;
         ADJ_UPPER_DEC  <= 1'b0;
         ADJ_LOWER_INC  <= 1'b0;
         ADJ_LOWER_DEC  <= 1'b0;
         ADJ_COARSE     <= 1'b0;
         UPPER_SRC      <= SRC_VOLT;
         LOWER_SRC      <= SRC_CURR;
         PROT_CODE      <= PROT_NONE;
         FAIL_INDICATOR <= 1'b0;
      end else begin
         ADJ_UPPER_INC  <= next_uinc;
         ADJ_UPPER_DEC  <= next_udec;
         ADJ_LOWER_INC  <= next_linc;
         ADJ_LOWER_DEC  <= next_ldec;
         ADJ_COARSE     <= next_coarse;
         UPPER_SRC      <= next_usrc;
         LOWER_SRC      <= next_lsrc;
         PROT_CODE      <= next_pcode;
         FAIL_INDICATOR <= next_fail;
      end
   end

   assign MODE_LEDS = {mode == const_power_mode,
                       mode == const_voltage_mode,
                       mode == const_resistance_mode,
                       mode == const_current_mode};
   assign REG_MODE   = mode;
   assign DYNAMIC    = dyn;
   assign HIGH_LEVEL = hi;
   assign LOAD_ON    = load;
   assign SHORT_ON   = shrt;
   assign DISP_MODE  = disp;
   assign MENU_POS   = menu;
   assign PROG_SEL   = sel;
   assign REMOTE_INDICATOR = REMOTE_ACTIVE;
   assign PRESET_AMBER = (disp == PRESET_ON);
   assign PRESET_GREEN = (disp == WATT_ON);
   assign LOAD_LED  = load;
   assign LEVEL_LED = hi;
   assign DYN_LED   = dyn;
   assign SHORT_LED = shrt;
   // limit lamp off only at off
   assign LIMIT_LED = (menu != 4'h0);
   genvar g;
   generate
      for (g = 0; g < 6; g++) begin : g_prog
         assign PROG_LEDS[g] = (sel == prog_sel_t'(g));
      end
   endgenerate
endmodule : load_front_panel_controller
`default_nettype wire

// >>> verification/load_front_panel_controller_asserts.sv
// load_front_panel_controller_asserts: port-level checks of the panel
// assumes binding to the controller top, one clock domain
`default_nettype none
module load_front_panel_controller_asserts (
   // clock and reset
   input wire logic                  CLK,
   input wire logic                  RESET,
   // watched inputs
   input wire logic                  REMOTE_ACTIVE,
   input wire logic [2:0]            ABOVE_UPPER,
   input wire logic [2:0]            BELOW_LOWER,
   input wire logic [3:0]            PROT_FLAGS,
   // watched outputs
   input wire logic [3:0]            MODE_LEDS,
   input wire panel_pkg::reg_mode_t  REG_MODE,
   input wire logic                  DYNAMIC,
   input wire logic                  HIGH_LEVEL,
   input wire logic                  LOAD_ON,
   input wire logic                  FAIL_INDICATOR,
   input wire logic                  REMOTE_INDICATOR,
   input wire logic                  PRESET_AMBER,
   input wire logic                  PRESET_GREEN,
   input wire panel_pkg::disp_mode_t DISP_MODE,
   input wire logic [3:0]            MENU_POS,
   input wire logic                  LIMIT_LED,
   input wire logic [5:0]            PROG_LEDS,
   input wire panel_pkg::prog_sel_t  PROG_SEL,
   input wire panel_pkg::meter_src_t LOWER_SRC,
   input wire logic [2:0]            PROT_CODE
);
   timeunit 1ns;
   timeprecision 100ps;
   import panel_pkg::*;
   wire logic out_of_lim = (|ABOVE_UPPER) | (|BELOW_LOWER);
   function automatic logic [1:0] succ(input logic [1:0] m);
      return m ^ ((m[1] ^ m[0]) ? 2'h2 : 2'h1);
   endfunction : succ
   function automatic logic [2:0] code_of(input logic [3:0] f);
      return f[0] ? PROT_OV : f[1] ? PROT_OC : f[2] ? PROT_OP : PROT_OT;
   endfunction : code_of
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);
   sequence s_remote_held;
      REMOTE_ACTIVE [*3];
   endsequence
   sequence s_prot_held;
      ((|PROT_FLAGS) && $stable(PROT_FLAGS)) [*3];
   endsequence
   a_mode_step: assert property (
      REG_MODE != $past(REG_MODE) |-> REG_MODE == succ($past(REG_MODE)))
      else $error("mode moved out of order");
   a_mode_lamp: assert property (
      MODE_LEDS == (4'h1 << {REG_MODE[1], ^REG_MODE}))
      else $error("mode lamps wrong");
   a_fail_lamp: assert property (
      !$past(RESET) |-> FAIL_INDICATOR == $past(out_of_lim))
      else $error("fail lamp wrong");
   a_remote_lamp: assert property (
      REMOTE_INDICATOR == REMOTE_ACTIVE) else $error("remote lamp wrong");
   a_remote_keys_dropped: assert property (
      s_remote_held |-> $stable(REG_MODE) && $stable(DISP_MODE)
         && $stable(MENU_POS) && $stable(LOAD_ON))
      else $error("key acted under remote");
   a_preset_lamp: assert property (
      PRESET_AMBER == (DISP_MODE == PRESET_ON)
         && PRESET_GREEN == (DISP_MODE == WATT_ON))
      else $error("preset lamp wrong");
   a_level_frozen: assert property (
      DYNAMIC && $past(DYNAMIC) |-> $stable(HIGH_LEVEL))
      else $error("level moved while dynamic");
   a_static_forced: assert property (
      REG_MODE[0] |-> !DYNAMIC)
      else $error("dynamic in resistance or voltage mode");
   a_limit_lamp: assert property (
      LIMIT_LED == (MENU_POS != 4'h0)) else $error("limit lamp wrong");
   a_prog_lamp: assert property (
      PROG_LEDS == (6'h1 << PROG_SEL)) else $error("program lamps wrong");
   a_prot_code: assert property (
      s_prot_held |-> LOWER_SRC == SRC_PROT
         && PROT_CODE == code_of(PROT_FLAGS))
      else $error("protection code wrong");
endmodule : load_front_panel_controller_asserts
bind load_front_panel_controller load_front_panel_controller_asserts u_chk (
   .CLK(CLK), .RESET(RESET), .REMOTE_ACTIVE(REMOTE_ACTIVE),
   .ABOVE_UPPER(ABOVE_UPPER), .BELOW_LOWER(BELOW_LOWER),
   .PROT_FLAGS(PROT_FLAGS), .MODE_LEDS(MODE_LEDS), .REG_MODE(REG_MODE),
   .DYNAMIC(DYNAMIC), .HIGH_LEVEL(HIGH_LEVEL), .LOAD_ON(LOAD_ON),
   .FAIL_INDICATOR(FAIL_INDICATOR), .REMOTE_INDICATOR(REMOTE_INDICATOR),
   .PRESET_AMBER(PRESET_AMBER), .PRESET_GREEN(PRESET_GREEN),
   .DISP_MODE(DISP_MODE), .MENU_POS(MENU_POS), .LIMIT_LED(LIMIT_LED),
   .PROG_LEDS(PROG_LEDS), .PROG_SEL(PROG_SEL), .LOWER_SRC(LOWER_SRC),
   .PROT_CODE(PROT_CODE)
);
`default_nettype wire

// >>> verification/load_front_panel_controller_tb_top.sv
// load_front_panel_controller_tb_top: scenario bench for the panel
// assumes a short debounce of 4 cycles and the operator model
`default_nettype none
module load_front_panel_controller_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import panel_pkg::*;
   logic clk, rst, go, fine_up, remote, busy;
   logic [3:0] idx, prot, mode_leds, menu_pos;
   logic [2:0] above, below, prot_code;
   logic [15:0] keys;
   logic [5:0] prog_leds;
   logic dyn, hi_lvl, load_on, short_on, fail_ind, rem_ind, amber, green;
   logic load_led, short_led, limit_led, adj_ui, adj_li, adj_co;
   logic adj_ud, adj_ld, lvl_led, dyn_led;
   reg_mode_t reg_mode;
   disp_mode_t disp;
   prog_sel_t prog_sel;
   meter_src_t upper_src, lower_src;
   int mismatches = 0;
   int checked = 0;
   int n_ui = 0;
   int n_li = 0;
   int n_co = 0;
   int n_ud = 0;
   int n_ld = 0;
   panel_operator op (.clk(clk), .go(go), .idx(idx), .keys(keys),
      .busy(busy));
   load_front_panel_controller #(.DEBOUNCE(4)) dut (
      .CLK(clk), .RESET(rst), .KEYS(keys), .FINE_UP(fine_up),
      .REMOTE_ACTIVE(remote), .ABOVE_UPPER(above), .BELOW_LOWER(below),
      .PROT_FLAGS(prot), .MODE_LEDS(mode_leds), .REG_MODE(reg_mode),
      .DYNAMIC(dyn), .HIGH_LEVEL(hi_lvl), .LOAD_ON(load_on),
      .SHORT_ON(short_on), .FAIL_INDICATOR(fail_ind),
      .REMOTE_INDICATOR(rem_ind), .PRESET_AMBER(amber),
      .PRESET_GREEN(green), .LOAD_LED(load_led), .LEVEL_LED(lvl_led),
      .DYN_LED(dyn_led), .SHORT_LED(short_led), .LIMIT_LED(limit_led),
      .PROG_LEDS(prog_leds), .DISP_MODE(disp), .MENU_POS(menu_pos),
      .PROG_SEL(prog_sel), .UPPER_SRC(upper_src), .LOWER_SRC(lower_src),
      .PROT_CODE(prot_code), .ADJ_UPPER_INC(adj_ui), .ADJ_UPPER_DEC(adj_ud),
      .ADJ_LOWER_INC(adj_li), .ADJ_LOWER_DEC(adj_ld), .ADJ_COARSE(adj_co));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // counts adjust pulses
   always @(posedge clk) begin
      if (adj_ui) n_ui++;
      if (adj_li) n_li++;
      if (adj_ud) n_ud++;
      if (adj_ld) n_ld++;
      if (adj_co) n_co++;
   end
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic press(input int k);
      idx <= 4'(k);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      for (int n = 0; n < 100; n++) begin
         @(posedge clk);
         if (!busy) return;
      end
      mismatches++;
      give_verdict;
   endtask : press
   task automatic t_mode;
      reg_mode_t m [4] = '{const_resistance_mode, const_voltage_mode,
                           const_power_mode, const_current_mode};
      logic [3:0] led [4] = '{4'h2, 4'h4, 4'h8, 4'h1};
      for (int i = 0; i < 4; i++) begin
         press(K_MODE);
         chk(reg_mode, m[i]);
         chk(mode_leds, led[i]);
      end
   endtask : t_mode
   task automatic t_preset;
      disp_mode_t d [3] = '{PRESET_ON, WATT_ON, PRESET_OFF};
      meter_src_t s [3] = '{SRC_PROG, SRC_POWER, SRC_VOLT};
      for (int i = 0; i < 3; i++) begin
         press(K_PRESET);
         chk(disp, d[i]);
         chk(16'({amber, green}), 16'(2 >> i));
         chk(upper_src, s[i]);
      end
   endtask : t_preset
   task automatic t_toggles;
      press(K_LOAD);
      chk(16'({load_on, load_led, reg_mode}), 16'hc);
      press(K_SHORT);
      chk(16'({short_on, short_led}), 16'h3);
      chk(lower_src, SRC_SHORT);
      press(K_SHORT);
      press(K_LOAD);
      chk(16'({load_led, short_led}), 16'h0);
      chk(lower_src, SRC_CURR);
   endtask : t_toggles
   task automatic t_dyn;
      press(K_DYNSTA);
      chk(16'({dyn, dyn_led}), 16'h3);
      press(K_LEVEL);
      chk(16'({hi_lvl, lvl_led}), 16'h0);
      press(K_MODE);
      chk(16'({dyn, dyn_led}), 16'h0);
      press(K_DYNSTA);
      press(K_MODE);
      press(K_DYNSTA);
      chk(dyn, 1'b0);
      press(K_MODE);
      press(K_DYNSTA);
      chk(dyn, 1'b1);
      press(K_DYNSTA);
      press(K_MODE);
      press(K_LEVEL);
      chk(16'({hi_lvl, lvl_led}), 16'h3);
      press(K_LEVEL);
      chk(16'({hi_lvl, lvl_led}), 16'h0);
   endtask : t_dyn
   task automatic t_sel;
      for (int k = K_HIGH_PER; k <= K_LOW_LVL; k++) begin
         press(k);
         chk(prog_sel, 16'((k - 5) % 6));
         chk(prog_leds, 16'(1 << ((k - 5) % 6)));
      end
   endtask : t_sel
   task automatic t_limit;
      int ui, li, co, ud, ld;
      for (int i = 1; i <= 16; i++) begin
         press(K_LIMIT);
         chk(menu_pos, 16'(i % 16));
         chk(limit_led, 16'(i != 16));
         chk(upper_src, (i != 16) ? SRC_LIMIT : SRC_VOLT);
         if (i == 1 || i == 5) begin
            ui = n_ui;
            li = n_li;
            co = n_co;
            ud = n_ud;
            ld = n_ld;
            press(K_FINE);
            press(K_COARSE_UP);
            fine_up <= 1'b0;
            press(K_FINE);
            press(K_COARSE_DN);
            fine_up <= 1'b1;
            chk(16'(n_ui - ui), (i == 1) ? 16'h1 : 16'h2);
            chk(16'(n_li - li), (i == 1) ? 16'h1 : 16'h0);
            chk(16'(n_ud - ud), (i == 1) ? 16'h1 : 16'h2);
            chk(16'(n_ld - ld), (i == 1) ? 16'h1 : 16'h0);
            chk(16'(n_co - co), (i == 1) ? 16'h0 : 16'h2);
         end
      end
   endtask : t_limit
   task automatic t_fail;
      for (int b = 0; b < 7; b++) begin
         above <= (b < 3) ? 3'(1 << b) : 3'h0;
         below <= (b >= 3 && b < 6) ? 3'(1 << (b - 3)) : 3'h0;
         repeat (3) @(posedge clk);
         chk(fail_ind, 16'(b < 6));
      end
   endtask : t_fail
   task automatic t_prot;
      logic [3:0] f [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hc};
      logic [2:0] c [5] = '{PROT_OV, PROT_OC, PROT_OP, PROT_OT, PROT_OP};
      for (int n = 0; n < 5; n++) begin
         prot <= f[n];
         repeat (4) @(posedge clk);
         chk(prot_code, c[n]);
         chk(lower_src, SRC_PROT);
      end
      prot <= 4'h0;
      repeat (4) @(posedge clk);
      chk(lower_src, SRC_CURR);
   endtask : t_prot
   task automatic t_remote;
      remote <= 1'b1;
      press(K_MODE);
      press(K_PRESET);
      chk(16'({rem_ind, reg_mode, disp}), 16'h13);
      remote <= 1'b0;
      press(K_MODE);
      chk(16'({rem_ind, reg_mode}), 16'h1);
   endtask : t_remote
   initial begin
      rst = 1'b1;
      go = 1'b0;
      idx = 4'h0;
      fine_up = 1'b1;
      remote = 1'b0;
      above = 3'h0;
      below = 3'h0;
      prot = 4'h0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_mode;
      t_preset;
      t_toggles;
      t_dyn;
      t_sel;
      t_limit;
      t_fail;
      t_prot;
      t_remote;
      give_verdict;
   end
endmodule : load_front_panel_controller_tb_top
`default_nettype wire

// >>> verification/panel_operator.sv
// panel_operator: a person at the keys, one closure per request
// assumes go is raised for one clock and busy is watched
`default_nettype none
module panel_operator #(
   parameter int HOLD = 12
) (
   // clock
   input  wire logic        clk,
   // request
   input  wire logic        go,
   input  wire logic [3:0]  idx,
   // keys and status
   output logic      [15:0] keys,
   output logic             busy
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      keys = 16'h0;
      busy = 1'b0;
      forever begin
         @(posedge clk);
         if (go) begin
            busy <= 1'b1;
            keys[idx] <= 1'b1;
            repeat (HOLD) @(posedge clk);
            keys <= 16'h0;
            repeat (HOLD) @(posedge clk);
            busy <= 1'b0;
         end
      end
   end
endmodule : panel_operator
`default_nettype wire
